/* File: src/pcpd_pkg.sv */
package pcpd_pkg;

  localparam logic [7:0] PCPD_ADDR_P2_DATA   = 8'ha0;
  localparam logic [7:0] PCPD_ADDR_P2_OTYPE  = 8'ha6;
  localparam logic [7:0] PCPD_ADDR_P3_DATA   = 8'hb0;
  localparam logic [7:0] PCPD_ADDR_P2_BYPASS = 8'hd6;
  localparam logic [7:0] PCPD_ADDR_P2_ANALOG = 8'hf3;
  localparam logic [7:0] PCPD_ADDR_P2_DRIVE  = 8'hfb;

  localparam logic [7:0] PCPD_PAGE_CONFIG    = 8'h0f;

  localparam logic [7:0] PCPD_RST_P2_DATA    = 8'hff;
  localparam logic [7:0] PCPD_RST_P2_OTYPE   = 8'h00;
  localparam logic [7:0] PCPD_RST_P3_DATA    = 8'hff;
  localparam logic [7:0] PCPD_RST_P2_BYPASS  = 8'h00;
  localparam logic [7:0] PCPD_RST_P2_ANALOG  = 8'hff;
  localparam logic [7:0] PCPD_RST_P2_DRIVE   = 8'h00;

  localparam logic [7:0] PCPD_READ_UNMAPPED  = 8'h00;

  typedef enum logic [2:0] {
    PCPD_SEL_NONE,
    PCPD_SEL_P2_DATA,
    PCPD_SEL_P2_OTYPE,
    PCPD_SEL_P3_DATA,
    PCPD_SEL_P2_BYPASS,
    PCPD_SEL_P2_ANALOG,
    PCPD_SEL_P2_DRIVE
  } pcpd_sel_type;

endpackage

/* File: src/pcpd_pin_cell.sv */
`timescale 1ns/100ps
`default_nettype none

// Pad control for one pin
module pcpd_pin_cell
(
  input  wire logic latch_i,
  input  wire logic digital_i,
  input  wire logic push_pull_i,
  input  wire logic high_drive_i,
  input  wire logic pad_in_i,
  output logic      pad_out_o,
  output logic      pad_oe_o,
  output logic      pullup_en_o,
  output logic      high_drive_o,
  output logic      in_level_o
);

  always_comb
  begin
    pad_out_o    = latch_i & digital_i; // R05
    // Open-drain drives only a low
    pad_oe_o     = digital_i & (push_pull_i | ~latch_i); // R05 R07 R08
    pullup_en_o  = digital_i & ~push_pull_i & latch_i; // R05
    high_drive_o = digital_i & high_drive_i; // R11
    in_level_o   = digital_i & pad_in_i; // R01 R05
  end

endmodule
`default_nettype wire

/* File: src/pcpd_port.sv */
`timescale 1ns/100ps
`default_nettype none

// What this block does
// R01: Data reads return pin levels, not latches
// R02: Port 2 read 0 low, 1 high
// R03: Port 3 write sets latch level
// R04: Port 2 write sets latch level
// R05: Analog pin disables pullup, driver, receiver
// R06: Analog select 0 analog, reset all ones
// R07: Output type ignored on analog pins
// R08: Output type 0 open-drain, 1 push-pull
// R09: Bypass bit 1 hides pin from crossbar
// R10: Software should bypass every used pin
// R11: Drive level 0 low, 1 high
// R12: Data registers on all pages, bit access
// R13: Port 2 config decoded only on page F
module pcpd_port
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_page_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_bit_wr_i,
  input  wire logic [2:0] sfr_bit_idx_i,
  input  wire logic       sfr_bit_val_i,
  output logic [7:0]      sfr_rdata_o,
  output logic            sfr_hit_o,
  input  wire logic [7:0] port2_pad_in_i,
  output logic [7:0]      port2_pad_out_o,
  output logic [7:0]      port2_pad_oe_o,
  output logic [7:0]      port2_pullup_en_o,
  output logic [7:0]      port2_high_drive_o,
  output logic [7:0]      port2_analog_o,
  output logic [7:0]      port2_crossbar_skip_o,
  input  wire logic [7:0] port3_pin_level_i,
  output logic [7:0]      port3_latch_o
);

  logic [7:0] port2_pin_data_r;
  logic [7:0] port2_pin_data_nxt;
  logic [7:0] port3_pin_data_r;
  logic [7:0] port3_pin_data_nxt;
  logic [7:0] port2_output_type_r;
  logic [7:0] port2_output_type_nxt;
  logic [7:0] port2_crossbar_bypass_r;
  logic [7:0] port2_crossbar_bypass_nxt;
  logic [7:0] port2_analog_select_r;
  logic [7:0] port2_analog_select_nxt;
  logic [7:0] port2_drive_level_r;
  logic [7:0] port2_drive_level_nxt;
  logic [7:0] sfr_rdata_r;
  logic [7:0] sfr_rdata_nxt;
  logic [7:0] port2_level;
  logic       bit_wr;
  pcpd_pkg::pcpd_sel_type byte_sel;
  pcpd_pkg::pcpd_sel_type bit_sel;

  // Data registers answer on every page, config only on page F
  function automatic pcpd_pkg::pcpd_sel_type sel_decode
  (
    input logic [7:0] addr,
    input logic [7:0] page
  );
    logic                   cfg;
    pcpd_pkg::pcpd_sel_type sel;
    cfg = (page == pcpd_pkg::PCPD_PAGE_CONFIG); // R13
    sel = pcpd_pkg::PCPD_SEL_NONE;
    case (addr)
      pcpd_pkg::PCPD_ADDR_P2_DATA:
      begin
        sel = pcpd_pkg::PCPD_SEL_P2_DATA; // R12
      end
      pcpd_pkg::PCPD_ADDR_P3_DATA:
      begin
        sel = pcpd_pkg::PCPD_SEL_P3_DATA; // R12
      end
      pcpd_pkg::PCPD_ADDR_P2_OTYPE:
      begin
        sel = cfg ? pcpd_pkg::PCPD_SEL_P2_OTYPE : pcpd_pkg::PCPD_SEL_NONE; // R13
      end
      pcpd_pkg::PCPD_ADDR_P2_BYPASS:
      begin
        sel = cfg ? pcpd_pkg::PCPD_SEL_P2_BYPASS : pcpd_pkg::PCPD_SEL_NONE; // R13
      end
      pcpd_pkg::PCPD_ADDR_P2_ANALOG:
      begin
        sel = cfg ? pcpd_pkg::PCPD_SEL_P2_ANALOG : pcpd_pkg::PCPD_SEL_NONE; // R13
      end
      pcpd_pkg::PCPD_ADDR_P2_DRIVE:
      begin
        sel = cfg ? pcpd_pkg::PCPD_SEL_P2_DRIVE : pcpd_pkg::PCPD_SEL_NONE; // R13
      end
      default:
      begin
        sel = pcpd_pkg::PCPD_SEL_NONE;
      end
    endcase
    return sel;
  endfunction

  // Only the data registers take single-bit writes
  function automatic logic bit_target(input pcpd_pkg::pcpd_sel_type sel);
    return (sel == pcpd_pkg::PCPD_SEL_P2_DATA) || (sel == pcpd_pkg::PCPD_SEL_P3_DATA); // R12
  endfunction

  always_comb
  begin
    byte_sel  = sel_decode(sfr_addr_i, sfr_page_i);
    bit_sel   = bit_target(byte_sel) ? byte_sel : pcpd_pkg::PCPD_SEL_NONE; // R12
    // Byte write wins if both strobes come together
    bit_wr    = sfr_bit_wr_i & ~sfr_wr_i;
    sfr_hit_o = ((sfr_rd_i | sfr_wr_i) & (byte_sel != pcpd_pkg::PCPD_SEL_NONE))
                | (bit_wr & (bit_sel != pcpd_pkg::PCPD_SEL_NONE)); // R12 R13
  end

  // Port 2 output latches, byte or single bit
  always_comb
  begin
    port2_pin_data_nxt = port2_pin_data_r;
    if (sfr_wr_i && (byte_sel == pcpd_pkg::PCPD_SEL_P2_DATA))
    begin
      port2_pin_data_nxt = sfr_wdata_i; // R04
    end
    else if (bit_wr && (bit_sel == pcpd_pkg::PCPD_SEL_P2_DATA))
    begin
      port2_pin_data_nxt[sfr_bit_idx_i] = sfr_bit_val_i; // R12
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port2_pin_data_r <= pcpd_pkg::PCPD_RST_P2_DATA;
    end
    else
    begin
      port2_pin_data_r <= port2_pin_data_nxt;
    end
  end

  // Port 3 output latches, byte or single bit
  always_comb
  begin
    port3_pin_data_nxt = port3_pin_data_r;
    if (sfr_wr_i && (byte_sel == pcpd_pkg::PCPD_SEL_P3_DATA))
    begin
      port3_pin_data_nxt = sfr_wdata_i; // R03
    end
    else if (bit_wr && (bit_sel == pcpd_pkg::PCPD_SEL_P3_DATA))
    begin
      port3_pin_data_nxt[sfr_bit_idx_i] = sfr_bit_val_i; // R12
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port3_pin_data_r <= pcpd_pkg::PCPD_RST_P3_DATA;
    end
    else
    begin
      port3_pin_data_r <= port3_pin_data_nxt;
    end
  end

  always_comb
  begin
    port2_output_type_nxt = port2_output_type_r;
    if (sfr_wr_i && (byte_sel == pcpd_pkg::PCPD_SEL_P2_OTYPE))
    begin
      port2_output_type_nxt = sfr_wdata_i; // R08
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port2_output_type_r <= pcpd_pkg::PCPD_RST_P2_OTYPE;
    end
    else
    begin
      port2_output_type_r <= port2_output_type_nxt;
    end
  end

  always_comb
  begin
    port2_crossbar_bypass_nxt = port2_crossbar_bypass_r;
    if (sfr_wr_i && (byte_sel == pcpd_pkg::PCPD_SEL_P2_BYPASS))
    begin
      port2_crossbar_bypass_nxt = sfr_wdata_i; // R09
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port2_crossbar_bypass_r <= pcpd_pkg::PCPD_RST_P2_BYPASS;
    end
    else
    begin
      port2_crossbar_bypass_r <= port2_crossbar_bypass_nxt;
    end
  end

  always_comb
  begin
    port2_analog_select_nxt = port2_analog_select_r;
    if (sfr_wr_i && (byte_sel == pcpd_pkg::PCPD_SEL_P2_ANALOG))
    begin
      port2_analog_select_nxt = sfr_wdata_i; // R06
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port2_analog_select_r <= pcpd_pkg::PCPD_RST_P2_ANALOG; // R06
    end
    else
    begin
      port2_analog_select_r <= port2_analog_select_nxt;
    end
  end

  always_comb
  begin
    port2_drive_level_nxt = port2_drive_level_r;
    if (sfr_wr_i && (byte_sel == pcpd_pkg::PCPD_SEL_P2_DRIVE))
    begin
      port2_drive_level_nxt = sfr_wdata_i; // R11
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port2_drive_level_r <= pcpd_pkg::PCPD_RST_P2_DRIVE;
    end
    else
    begin
      port2_drive_level_r <= port2_drive_level_nxt;
    end
  end

  // Read data is held until the next read
  always_comb
  begin
    sfr_rdata_nxt = sfr_rdata_r;
    if (sfr_rd_i)
    begin
      case (byte_sel)
        pcpd_pkg::PCPD_SEL_P2_DATA:
        begin
          sfr_rdata_nxt = port2_level; // R01 R02
        end
        pcpd_pkg::PCPD_SEL_P3_DATA:
        begin
          sfr_rdata_nxt = port3_pin_level_i; // R01
        end
        pcpd_pkg::PCPD_SEL_P2_OTYPE:
        begin
          sfr_rdata_nxt = port2_output_type_r;
        end
        pcpd_pkg::PCPD_SEL_P2_BYPASS:
        begin
          sfr_rdata_nxt = port2_crossbar_bypass_r;
        end
        pcpd_pkg::PCPD_SEL_P2_ANALOG:
        begin
          sfr_rdata_nxt = port2_analog_select_r;
        end
        pcpd_pkg::PCPD_SEL_P2_DRIVE:
        begin
          sfr_rdata_nxt = port2_drive_level_r;
        end
        default:
        begin
          sfr_rdata_nxt = pcpd_pkg::PCPD_READ_UNMAPPED;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sfr_rdata_r <= pcpd_pkg::PCPD_READ_UNMAPPED;
    end
    else
    begin
      sfr_rdata_r <= sfr_rdata_nxt;
    end
  end

  genvar pin;
  generate
    for (pin = 0; pin < 8; pin++)
    begin : g_pin
      pcpd_pin_cell u_cell
      (
        .latch_i      (port2_pin_data_r[pin]),
        .digital_i    (port2_analog_select_r[pin]), // R06
        .push_pull_i  (port2_output_type_r[pin]), // R08
        .high_drive_i (port2_drive_level_r[pin]), // R11
        .pad_in_i     (port2_pad_in_i[pin]),
        .pad_out_o    (port2_pad_out_o[pin]),
        .pad_oe_o     (port2_pad_oe_o[pin]),
        .pullup_en_o  (port2_pullup_en_o[pin]),
        .high_drive_o (port2_high_drive_o[pin]),
        .in_level_o   (port2_level[pin]) // R01
      );
    end
  endgenerate

  always_comb
  begin
    port2_analog_o        = ~port2_analog_select_r; // R06
    port2_crossbar_skip_o = port2_crossbar_bypass_r; // R09
    port3_latch_o         = port3_pin_data_r; // R03
    sfr_rdata_o           = sfr_rdata_r;
  end

endmodule
`default_nettype wire

/* File: tb/pcpd_port_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module pcpd_port_chk
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_bit_wr_i,
  input wire logic [2:0] sfr_bit_idx_i,
  input wire logic       sfr_bit_val_i,
  input wire logic       sfr_hit_o,
  input wire logic [7:0] port2_analog_o,
  input wire logic [7:0] port2_pullup_en_o,
  input wire logic [7:0] port2_pad_oe_o,
  input wire logic [7:0] port2_crossbar_skip_o,
  input wire logic [7:0] port3_latch_o
);
  sequence on_config_page;
    sfr_page_i == pcpd_pkg::PCPD_PAGE_CONFIG;
  endsequence
  sequence off_config_page;
    sfr_page_i != pcpd_pkg::PCPD_PAGE_CONFIG;
  endsequence
  sequence analog_write;
    sfr_wr_i && sfr_addr_i == pcpd_pkg::PCPD_ADDR_P2_ANALOG;
  endsequence
  sequence bypass_write;
    sfr_wr_i && sfr_addr_i == pcpd_pkg::PCPD_ADDR_P2_BYPASS;
  endsequence
  sequence p3_byte_write;
    sfr_wr_i && sfr_addr_i == pcpd_pkg::PCPD_ADDR_P3_DATA;
  endsequence
  sequence p3_bit_write;
    sfr_bit_wr_i && !sfr_wr_i && sfr_addr_i == pcpd_pkg::PCPD_ADDR_P3_DATA;
  endsequence
  analog_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ~|(port2_analog_o & (port2_pullup_en_o | port2_pad_oe_o))) else $error("analog pin live");
  p3_reset_a: assert property (@(posedge clk_i) $fell(rst_i) |-> port3_latch_o == 8'hff)
    else $error("latch reset");
  p3_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    p3_byte_write |=> port3_latch_o == $past(sfr_wdata_i)) else $error("port 3 byte write");
  p3_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    p3_bit_write |=> port3_latch_o[$past(sfr_bit_idx_i)] == $past(sfr_bit_val_i))
    else $error("port 3 bit write");
  analog_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_write ##0 on_config_page |=> port2_analog_o == ~$past(sfr_wdata_i))
    else $error("analog select write");
  config_page_a: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_write ##0 off_config_page |=> $stable(port2_analog_o))
    else $error("config write off page");
  skip_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bypass_write ##0 on_config_page |=> port2_crossbar_skip_o == $past(sfr_wdata_i))
    else $error("bypass write");
  data_hit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sfr_rd_i && (sfr_addr_i == pcpd_pkg::PCPD_ADDR_P2_DATA
    || sfr_addr_i == pcpd_pkg::PCPD_ADDR_P3_DATA) |-> sfr_hit_o) else $error("data reg miss");
  od_pullup_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ~|(port2_pullup_en_o & port2_pad_oe_o)) else $error("pullup while driving");
endmodule
`default_nettype wire

/* File: tb/pcpd_pad_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pcpd_pad_model(input wire logic [7:0] out_i, input wire logic [7:0] oe_i,
  input wire logic [7:0] l3_i, output logic [7:0] p2_o, output logic [7:0] p3_o);
  // Undriven pins float high through the pull
  assign p2_o = (oe_i & out_i) | ~oe_i;
  assign p3_o = l3_i;
endmodule
`default_nettype wire

/* File: tb/pcpd_port_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,s) begin samples_checked++; exp_v = (e); if ((s) !== exp_v) begin failures++; \
  $display("wrong value %s exp %h got %h", n, exp_v, (s)); end end
module pcpd_port_tb;
  logic clk_i=0, rst_i=1, sfr_wr_i=0, sfr_rd_i=0, sfr_bit_wr_i=0, sfr_bit_val_i=0, sfr_hit_o;
  logic [2:0] sfr_bit_idx_i=0;
  logic [7:0] sfr_addr_i=0, sfr_page_i=0, sfr_wdata_i=0, sfr_rdata_o, r, port2_pad_in_i;
  logic [7:0] port2_pad_out_o, port2_pad_oe_o, port2_pullup_en_o, port2_high_drive_o;
  logic [7:0] port2_analog_o, port2_crossbar_skip_o, port3_pin_level_i, port3_latch_o;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v, dmask, r2, dr;
  logic       rd_pend = 0;
  int failures=0, samples_checked=0;
  always #4 clk_i = ~clk_i;
  pcpd_port uut
  (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .sfr_addr_i            (sfr_addr_i),
    .sfr_page_i            (sfr_page_i),
    .sfr_wr_i              (sfr_wr_i),
    .sfr_rd_i              (sfr_rd_i),
    .sfr_wdata_i           (sfr_wdata_i),
    .sfr_bit_wr_i          (sfr_bit_wr_i),
    .sfr_bit_idx_i         (sfr_bit_idx_i),
    .sfr_bit_val_i         (sfr_bit_val_i),
    .sfr_rdata_o           (sfr_rdata_o),
    .sfr_hit_o             (sfr_hit_o),
    .port2_pad_in_i        (port2_pad_in_i),
    .port2_pad_out_o       (port2_pad_out_o),
    .port2_pad_oe_o        (port2_pad_oe_o),
    .port2_pullup_en_o     (port2_pullup_en_o),
    .port2_high_drive_o    (port2_high_drive_o),
    .port2_analog_o        (port2_analog_o),
    .port2_crossbar_skip_o (port2_crossbar_skip_o),
    .port3_pin_level_i     (port3_pin_level_i),
    .port3_latch_o         (port3_latch_o)
  );
  pcpd_pad_model pads(.out_i(port2_pad_out_o), .oe_i(port2_pad_oe_o), .l3_i(port3_latch_o),
    .p2_o(port2_pad_in_i), .p3_o(port3_pin_level_i));
  task acc(input logic w, input logic [7:0] pg, a, d, e);
    @(negedge clk_i);
    sfr_wr_i = w;
    sfr_rd_i = !w;
    sfr_page_i = pg;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    if (!w) exp_q.push_back(e);
    @(negedge clk_i);
    sfr_wr_i = 0;
    sfr_rd_i = 0;
  endtask
  task bitw(input logic [7:0] a, input logic [2:0] i, input logic v);
    @(negedge clk_i);
    sfr_bit_wr_i = 1;
    sfr_page_i = 8'h05;
    sfr_addr_i = a;
    sfr_bit_idx_i = i;
    sfr_bit_val_i = v;
    @(negedge clk_i);
    sfr_bit_wr_i = 0;
  endtask
  task close_out;
    failures += exp_q.size();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures==0 && samples_checked>0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Read data stands from the edge after the read
  always @(posedge clk_i)
  begin
    if (rd_pend) `CHK("rdata", exp_q.pop_front(), sfr_rdata_o)
    rd_pend <= sfr_rd_i && sfr_hit_o;
  end
  initial
  begin
    #20000;
    failures++;
    close_out;
  end
  initial
  begin
    r = $urandom(32'h5348);
    repeat (16) @(negedge clk_i);
    rst_i = 0;
    acc(0, 8'h0f, pcpd_pkg::PCPD_ADDR_P2_ANALOG, 8'h00, 8'hff);
    acc(0, 8'h03, pcpd_pkg::PCPD_ADDR_P2_DATA, 8'h00, 8'hff);
    r = $urandom;
    acc(1, 8'h00, pcpd_pkg::PCPD_ADDR_P3_DATA, r, 8'h00);
    acc(0, 8'h07, pcpd_pkg::PCPD_ADDR_P3_DATA, 8'h00, r);
    bitw(pcpd_pkg::PCPD_ADDR_P3_DATA, 3'h3, ~r[3]);
    acc(0, 8'h02, pcpd_pkg::PCPD_ADDR_P3_DATA, 8'h00, r ^ 8'h08);
    acc(1, 8'h00, pcpd_pkg::PCPD_ADDR_P2_ANALOG, 8'h00, 8'h00);
    acc(0, 8'h0f, pcpd_pkg::PCPD_ADDR_P2_ANALOG, 8'h00, 8'hff);
    dmask = $urandom;
    acc(1, 8'h0f, pcpd_pkg::PCPD_ADDR_P2_BYPASS, 8'hff, 8'h00);
    acc(1, 8'h0f, pcpd_pkg::PCPD_ADDR_P2_ANALOG, dmask, 8'h00);
    r2 = $urandom;
    acc(1, 8'h04, pcpd_pkg::PCPD_ADDR_P2_DATA, r2, 8'h00);
    acc(0, 8'h01, pcpd_pkg::PCPD_ADDR_P2_DATA, 8'h00, r2 & dmask);
    acc(1, 8'h0f, pcpd_pkg::PCPD_ADDR_P2_OTYPE, 8'hff, 8'h00);
    acc(0, 8'h0f, pcpd_pkg::PCPD_ADDR_P2_OTYPE, 8'h00, 8'hff);
    acc(0, 8'h0f, pcpd_pkg::PCPD_ADDR_P2_DATA, 8'h00, r2 & dmask);
    dr = $urandom;
    acc(1, 8'h0f, pcpd_pkg::PCPD_ADDR_P2_DRIVE, dr, 8'h00);
    acc(0, 8'h0f, pcpd_pkg::PCPD_ADDR_P2_DRIVE, 8'h00, dr);
    acc(0, 8'h0f, pcpd_pkg::PCPD_ADDR_P2_BYPASS, 8'h00, 8'hff);
    `CHK("high_drive", dr & dmask, port2_high_drive_o)
    `CHK("crossbar_skip", 8'hff, port2_crossbar_skip_o)
    `CHK("analog", ~dmask, port2_analog_o)
    `CHK("pad_out", r2 & dmask, port2_pad_out_o)
    `CHK("pullup", 8'h00, port2_pullup_en_o)
    `CHK("pad_oe", dmask, port2_pad_oe_o)
    repeat (2) @(negedge clk_i);
    close_out;
  end
endmodule
bind pcpd_port pcpd_port_chk chk(.*);
`default_nettype wire
